// ---- core/tcc_top.sv ----
// Triple comparator control: registers, sampling, flags, capture route
//
// How it works
// - Output bit high when positive input exceeds selected negative input.
// - New sample each comparator clock, I/O clock or half of it.
// - Each comparator has its own dedicated interrupt request line.
// - Sense 00 toggle, 10 falling, 11 rising, 01 reserved.
// - Control bit 7 enables the comparator; zero disables it.
// - Interrupt request forwarded only while control bit 6 is one.
// - Three-bit negative select: four reference fractions, pin, DAC.
// - Four reference levels derive from converter reference select bits.
// - Capture route bit 3 sends comparator 1 to timer capture.
// - Timer edge select one picks rising, zero picks falling edge.
// - Route bit zero disconnects comparator 1 from timer capture.
// - Each interrupt flag is offered as a conversion trigger.
// - Flag set by event; cleared on vector ack while control bit 6 is one, or written one.
// - Halving bit one halves comparator clock; zero keeps full rate.
// - Each sampled output readable as a status bit.
`timescale 1ns/10ps
module tcc_top
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [TCC_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Analog comparator cores
	input wire logic [TCC_NUM-1:0] cmp_raw,
	output tcc_ana_s [TCC_NUM-1:0] ana_ctl,
	// Converter reference select
	input wire logic [1:0] converter_ref_select,
	// Interrupts
	input wire logic [TCC_NUM-1:0] irq_ack,
	output logic [TCC_NUM-1:0] irq_req,
	output logic irq,
	// Conversion triggers
	output logic [TCC_NUM-1:0] conv_trigger,
	// Timer capture front end
	input wire logic timer_capture_edge_sel,
	output logic capture_level,
	output logic capture_event
);

	tcc_ctrl_s [TCC_NUM-1:0] ctrl_q;
	logic halving_q, phase_q, ack_q;
	logic [TCC_NUM-1:0] flag_q, flag_d, mask_q;
	logic [TCC_NUM-1:0] samp, ev, w1c, hw_clr;
	logic [1:0] ref_q;
	logic [31:0] readdata_q;
	logic cap_prev_q, cap_level_q, cap_event_q;
	logic sample_en, req, take, wr_go, rd_first;
	logic sel_c0, sel_c1, sel_c2, sel_st, sel_mk;
	logic [7:0] stat_rd, rd_mux, wr8;
	logic cap_rise, cap_fall;

	// Bus handshake: one wait cycle, taken on the second edge
	assign req = read | write;
	assign waitrequest = req & ~ack_q;
	assign take = req & ack_q;
	assign wr_go = write & take & byteenable[0];
	assign rd_first = read & ~ack_q;
	assign wr8 = writedata[7:0];

	assign sel_c0 = (address == TCC_OFS_CTRL0);
	assign sel_c1 = (address == TCC_OFS_CTRL1);
	assign sel_c2 = (address == TCC_OFS_CTRL2);
	assign sel_st = (address == TCC_OFS_STAT);
	assign sel_mk = (address == TCC_OFS_MASK);

	assign stat_rd = {halving_q, flag_q, 1'b0, samp};
	assign rd_mux = sel_c0 ? {ctrl_q[0][7:4], 1'b0, ctrl_q[0][2:0]} :
		sel_c1 ? ctrl_q[1] :
		sel_c2 ? {ctrl_q[2][7:4], 1'b0, ctrl_q[2][2:0]} :
		sel_st ? stat_rd :
		sel_mk ? {1'b0, mask_q, 4'h0} : 8'h00;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
			readdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= req & ~ack_q;
			if (rd_first) begin
				readdata_q <= {24'h00_0000, rd_mux};
			end
		end
	end
	assign readdata = readdata_q;

	// Control registers
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl_q <= {TCC_NUM{TCC_CTRL_RST}};
			halving_q <= TCC_STAT_RST[TCC_STAT_HALVING];
			mask_q <= TCC_MASK_RST[6:4];
		end else if (wr_go) begin
			if (sel_c0) begin
				ctrl_q[0] <= {wr8[7:4], 1'b0, wr8[2:0]};
			end
			if (sel_c1) begin
				ctrl_q[1] <= wr8;
			end
			if (sel_c2) begin
				ctrl_q[2] <= {wr8[7:4], 1'b0, wr8[2:0]};
			end
			if (sel_st) begin
				halving_q <= wr8[TCC_STAT_HALVING];
			end
			if (sel_mk) begin
				mask_q <= wr8[6:4];
			end
		end
	end

	// Comparator clock as enable pulse
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= ~phase_q;
		end
	end
	assign sample_en = ~halving_q | phase_q;

	// Reference source to the ladder follows the converter select
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ref_q <= 2'b00;
		end else begin
			ref_q <= converter_ref_select;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < TCC_NUM; gi++) begin : g_cmp
			tcc_sampler u_smp (
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.sample_en(sample_en),
				.on(ctrl_q[gi].on),
				.sense(ctrl_q[gi].sense),
				.raw_in(cmp_raw[gi]),
				.sample_q(samp[gi]),
				.event_q(ev[gi])
			);
			assign ana_ctl[gi].on = ctrl_q[gi].on;
			assign ana_ctl[gi].neg_sel = ctrl_q[gi].neg_sel;
			assign ana_ctl[gi].ref_sel = ref_q;
			assign w1c[gi] = wr_go & sel_st & wr8[TCC_STAT_FLAG0 + gi];
			assign hw_clr[gi] = irq_ack[gi] & ctrl_q[gi].irq_on;
			// Set wins over either clear
			assign flag_d[gi] = ev[gi] | (flag_q[gi] & ~(w1c[gi] | hw_clr[gi]));
			assign irq_req[gi] = flag_q[gi] & ctrl_q[gi].irq_on;
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			flag_q <= TCC_STAT_RST[6:4];
		end else begin
			flag_q <= flag_d;
		end
	end

	assign irq = |(irq_req & mask_q);
	assign conv_trigger = flag_q;

	// Comparator 1 path into timer capture
	assign cap_rise = samp[1] & ~cap_prev_q;
	assign cap_fall = ~samp[1] & cap_prev_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cap_prev_q <= 1'b0;
			cap_level_q <= 1'b0;
			cap_event_q <= 1'b0;
		end else begin
			cap_prev_q <= samp[1];
			cap_level_q <= ctrl_q[1].cap & samp[1];
			cap_event_q <= ctrl_q[1].cap &
				(timer_capture_edge_sel ? cap_rise : cap_fall);
		end
	end
	assign capture_level = cap_level_q;
	assign capture_event = cap_event_q;

	// Checks
	property p_wait_first;
		@(posedge clk_sys) disable iff (!rst_b)
		(req && !ack_q) |-> waitrequest ##1 (!req || !waitrequest);
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("waitrequest timing wrong");

	property p_halve;
		@(posedge clk_sys) disable iff (!rst_b)
		(halving_q && sample_en) ##1 halving_q |-> !sample_en;
	endproperty
	a_halve: assert property (p_halve) else $error("halved clock pulses too often");

	property p_full_rate;
		@(posedge clk_sys) disable iff (!rst_b)
		!halving_q |-> sample_en;
	endproperty
	a_full_rate: assert property (p_full_rate) else $error("full rate sample missing");

	property p_flag_set;
		@(posedge clk_sys) disable iff (!rst_b)
		ev[0] |=> flag_q[0] && conv_trigger[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

	property p_w1c;
		@(posedge clk_sys) disable iff (!rst_b)
		(w1c[2] && !ev[2]) |=> !flag_q[2];
	endproperty
	a_w1c: assert property (p_w1c) else $error("written one did not clear flag");

	property p_irq_gate;
		@(posedge clk_sys) disable iff (!rst_b)
		(!ctrl_q[1].irq_on && !(flag_q[0] && ctrl_q[0].irq_on) &&
			!(flag_q[2] && ctrl_q[2].irq_on)) |-> !irq && !irq_req[1];
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without enable");

	property p_off;
		@(posedge clk_sys) disable iff (!rst_b)
		!ctrl_q[0].on |=> !samp[0] && !ev[0];
	endproperty
	a_off: assert property (p_off) else $error("disabled comparator active");

	property p_rise_only;
		@(posedge clk_sys) disable iff (!rst_b)
		(ev[1] && ctrl_q[1].sense == TCC_SENSE_RISE) |-> samp[1] && !$past(samp[1]);
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("rise event without rise");

	property p_cap_off;
		@(posedge clk_sys) disable iff (!rst_b)
		!ctrl_q[1].cap |=> !capture_level && !capture_event;
	endproperty
	a_cap_off: assert property (p_cap_off) else $error("capture path not cut");

	property p_cap_edge;
		@(posedge clk_sys) disable iff (!rst_b)
		(ctrl_q[1].cap && timer_capture_edge_sel && cap_rise) |=> capture_event;
	endproperty
	a_cap_edge: assert property (p_cap_edge) else $error("rising capture missed");

	property p_status_out;
		@(posedge clk_sys) disable iff (!rst_b)
		rd_first && sel_st |=> readdata[2:0] == $past(samp);
	endproperty
	a_status_out: assert property (p_status_out) else $error("status output bits wrong");

	c_toggle: cover property (@(posedge clk_sys) disable iff (!rst_b)
		ev[0] && ctrl_q[0].sense == TCC_SENSE_TOGGLE);
	c_halved_event: cover property (@(posedge clk_sys) disable iff (!rst_b)
		ev[0] && halving_q);
	c_capture: cover property (@(posedge clk_sys) disable iff (!rst_b) capture_event);
	c_irq: cover property (@(posedge clk_sys) disable iff (!rst_b) irq);

endmodule

// ---- include/tcc_pkg.sv ----
// Shared constants and types of the triple comparator control block
package tcc_pkg;

	localparam int TCC_NUM = 3;
	localparam int TCC_ADDR_W = 5;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [4:0] TCC_OFS_CTRL0 = 5'h00;
	localparam logic [4:0] TCC_OFS_CTRL1 = 5'h04;
	localparam logic [4:0] TCC_OFS_CTRL2 = 5'h08;
	localparam logic [4:0] TCC_OFS_STAT = 5'h0c;
	localparam logic [4:0] TCC_OFS_MASK = 5'h10;

	// Reset values
	localparam logic [7:0] TCC_CTRL_RST = 8'h00;
	localparam logic [7:0] TCC_STAT_RST = 8'h00;
	localparam logic [7:0] TCC_MASK_RST = 8'h00;

	// Control register field positions
	localparam int TCC_CTRL_ON = 7;
	localparam int TCC_CTRL_IRQ_ON = 6;
	localparam int TCC_CTRL_CAP = 3;

	// Status register field positions
	localparam int TCC_STAT_HALVING = 7;
	localparam int TCC_STAT_FLAG0 = 4;
	localparam int TCC_STAT_OUT0 = 0;

	// Comparator clock divide ratio when halving is on
	localparam int TCC_CLK_DIV = 2;

	typedef enum logic [1:0] {
		TCC_SENSE_TOGGLE = 2'b00,
		TCC_SENSE_RSVD = 2'b01,
		TCC_SENSE_FALL = 2'b10,
		TCC_SENSE_RISE = 2'b11
	} tcc_sense_e;

	typedef enum logic [2:0] {
		TCC_NEG_REF_6P40 = 3'b000,
		TCC_NEG_REF_3P20 = 3'b001,
		TCC_NEG_REF_2P13 = 3'b010,
		TCC_NEG_REF_1P60 = 3'b011,
		TCC_NEG_PIN = 3'b100,
		TCC_NEG_DAC = 3'b101,
		TCC_NEG_RSVD6 = 3'b110,
		TCC_NEG_RSVD7 = 3'b111
	} tcc_negsel_e;

	typedef struct packed {
		logic on;
		logic irq_on;
		tcc_sense_e sense;
		logic cap;
		tcc_negsel_e neg_sel;
	} tcc_ctrl_s;

	typedef struct packed {
		logic on;
		tcc_negsel_e neg_sel;
		logic [1:0] ref_sel;
	} tcc_ana_s;

endpackage

// ---- core/tcc_sampler.sv ----
// One comparator: pin synchroniser, clocked sample and edge event
`timescale 1ns/10ps
module tcc_sampler
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Control
	input wire logic sample_en,
	input wire logic on,
	input wire tcc_sense_e sense,
	// Analog core result
	input wire logic raw_in,
	// Results
	output logic sample_q,
	output logic event_q
);

	logic s1_q, s2_q, s3_q, level_q, armed_q;
	logic new_val, rose, fell, hit;

	// Change accepted once second and third stages agree
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= raw_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end

	assign new_val = level_q;
	assign rose = new_val & ~sample_q;
	assign fell = ~new_val & sample_q;
	assign hit = (sense == TCC_SENSE_TOGGLE) ? (rose | fell) :
		(sense == TCC_SENSE_FALL) ? fell :
		(sense == TCC_SENSE_RISE) ? rose : 1'b0;

	// Sample on comparator clock, edge against previous sample
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sample_q <= 1'b0;
			armed_q <= 1'b0;
			event_q <= 1'b0;
		end else if (!on) begin
			sample_q <= 1'b0;
			armed_q <= 1'b0;
			event_q <= 1'b0;
		end else if (sample_en) begin
			sample_q <= new_val;
			armed_q <= 1'b1;
			event_q <= armed_q & hit;
		end else begin
			event_q <= 1'b0;
		end
	end

endmodule

// ---- tb/tcc_ana_model.sv ----
// Behavioural model of the three analog comparator cores
`timescale 1ns/10ps
module tcc_ana_model
	import tcc_pkg::*;
#(
	parameter int VREF_MV = 2560
)(
	// Control from the block
	input wire tcc_ana_s [TCC_NUM-1:0] ana_ctl,
	// Analog levels in millivolts
	input wire logic [TCC_NUM-1:0][15:0] pos_mv,
	input wire logic [15:0] pin_mv,
	input wire logic [15:0] dac_mv,
	// Comparator results
	output logic [TCC_NUM-1:0] cmp_raw
);
	function automatic int neg_mv(tcc_ana_s c);
		int vr;
		vr = VREF_MV >> c.ref_sel;
		case (c.neg_sel)
			TCC_NEG_REF_6P40: return vr * 100 / 640;
			TCC_NEG_REF_3P20: return vr * 100 / 320;
			TCC_NEG_REF_2P13: return vr * 100 / 213;
			TCC_NEG_REF_1P60: return vr * 100 / 160;
			TCC_NEG_DAC: return dac_mv;
			default: return pin_mv;
		endcase
	endfunction
	always_comb begin
		for (int i = 0; i < TCC_NUM; i++) begin
			cmp_raw[i] = ana_ctl[i].on && (int'(pos_mv[i]) > neg_mv(ana_ctl[i]));
		end
	end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench of the triple comparator control block
`timescale 1ns/10ps
module tb_top
	import tcc_pkg::*;
;
	logic clk_sys, rst_b, read, write, waitrequest, irq;
	logic timer_capture_edge_sel, capture_level, capture_event;
	logic [4:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata, v, rise, fall;
	logic [31:0] rd_q [$];
	logic [2:0] cmp_raw, irq_ack, irq_req, conv_trigger;
	logic [1:0] converter_ref_select;
	tcc_ana_s [2:0] ana_ctl;
	logic [2:0][15:0] pos_mv;
	logic [15:0] pin_mv, dac_mv;
	int err_total, n_compared, cyc, caps, c0, seed;

	tcc_top u_dut (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.address(address),
		.read(read),
		.write(write),
		.byteenable(byteenable),
		.writedata(writedata),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.cmp_raw(cmp_raw),
		.ana_ctl(ana_ctl),
		.converter_ref_select(converter_ref_select),
		.irq_ack(irq_ack),
		.irq_req(irq_req),
		.irq(irq),
		.conv_trigger(conv_trigger),
		.timer_capture_edge_sel(timer_capture_edge_sel),
		.capture_level(capture_level),
		.capture_event(capture_event)
	);
	tcc_ana_model u_ana (.ana_ctl, .pos_mv, .pin_mv, .dac_mv, .cmp_raw);

	initial begin
		clk_sys = 0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Avalon request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do @(posedge clk_sys); while (waitrequest);
		write <= 0;
		read <= 0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(0, a, 32'h0);
	endtask

	task automatic setp(input int i, input logic [15:0] mv);
		@(posedge clk_sys);
		pos_mv[i] <= mv;
		wt(20);
	endtask

	task automatic ack(input logic [2:0] a);
		@(posedge clk_sys);
		irq_ack <= a;
		@(posedge clk_sys);
		irq_ack <= 3'b000;
	endtask

	// Read results checked against the oldest note
	always @(posedge clk_sys) begin
		if (read === 1'b1 && waitrequest === 1'b0) begin
			chk(readdata, rd_q.pop_front());
		end
		if (capture_event === 1'b1) begin
			caps++;
		end
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			finish_test();
		end
	end

	initial begin
		seed = 32'h22f9;
		{rst_b, read, write, address, writedata, irq_ack, converter_ref_select} = '0;
		pos_mv = '0;
		byteenable = 4'hf;
		timer_capture_edge_sel = 0;
		pin_mv = 16'd1000;
		dac_mv = 16'd500;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1;
		bus(1, 5'h14, 32'hff);
		for (int a = 0; a < 6; a++) begin
			rd(5'(a * 4), 32'h0);
		end
		for (int i = 0; i < 3; i++) begin
			v = $random(seed);
			bus(1, 5'(i * 4), v);
			rd(5'(i * 4), {24'h0, v[7:4], v[3] & (i == 1), v[2:0]});
			chk(32'(ana_ctl[i]), {26'h0, v[7], v[2:0], 2'b00});
		end
		converter_ref_select <= 2'b10;
		wt(3);
		chk(32'(ana_ctl[0].ref_sel), 32'h2);
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			for (int s = 0; s < 4; s++) begin
				rise = (s == 0 || s == 3);
				fall = (s == 0 || s == 2);
				bus(1, 5'(i * 4), {24'h0, 2'b10, 2'(s), 4'h4});
				bus(1, TCC_OFS_STAT, 32'h70);
				setp(i, 16'd2000);
				rd(TCC_OFS_STAT, (rise << (4 + i)) | (1 << i));
				chk(32'(conv_trigger), rise << i);
				bus(1, TCC_OFS_STAT, 32'h70);
				setp(i, 16'd0);
				rd(TCC_OFS_STAT, fall << (4 + i));
			end
		end
		$display("test sense done");
		bus(1, TCC_OFS_STAT, 32'h70);
		bus(1, TCC_OFS_CTRL2, 32'hc4);
		setp(2, 16'd2000);
		chk(32'(irq_req), 32'h4);
		chk(32'(irq), 32'h0);
		bus(1, TCC_OFS_MASK, 32'h40);
		rd(TCC_OFS_MASK, 32'h40);
		chk(32'(irq), 32'h1);
		ack(3'b100);
		rd(TCC_OFS_STAT, 32'h4);
		chk(32'(irq), 32'h0);
		bus(1, TCC_OFS_CTRL2, 32'h84);
		setp(2, 16'd0);
		ack(3'b100);
		rd(TCC_OFS_STAT, 32'h40);
		chk(32'(irq_req), 32'h0);
		bus(1, TCC_OFS_STAT, 32'h70);
		$display("test interrupt done");
		bus(1, TCC_OFS_CTRL1, 32'h8c);
		for (int e = 0; e < 2; e++) begin
			timer_capture_edge_sel <= e[0];
			c0 = caps;
			setp(1, 16'd2000);
			chk(caps - c0, e);
			chk(32'(capture_level), 32'h1);
			setp(1, 16'd0);
			chk(caps - c0, 1);
		end
		bus(1, TCC_OFS_CTRL1, 32'h84);
		c0 = caps;
		setp(1, 16'd2000);
		chk(32'(capture_level), 32'h0);
		setp(1, 16'd0);
		chk(caps - c0, 0);
		$display("test capture done");
		bus(1, TCC_OFS_STAT, 32'hf0);
		bus(1, TCC_OFS_CTRL0, 32'hb4);
		setp(0, 16'd2000);
		rd(TCC_OFS_STAT, 32'h91);
		$display("test halving done");
		finish_test();
	end
endmodule
